//--- src/block_ram_pkg.sv
// How it works
// - 18 kb array with input and output registers.
// - Modes: single, true dual, pseudo dual, ROM, FIFO.
// - Widths 1 to 36; true dual caps at 18 unless ECC forces 36.
// - FIFO keeps counters and four flags; only almost-full and almost-empty are programmable.
// - Optional parity bit generated per stored byte.
// - Byte enables act only at 18 or 36.
// - Port A ECC writes take 32-bit words only.
// - Check bits computed and stored per word on port A writes only.
// - Reads check and correct single-bit upsets.
// - Separate single-bit and double-bit error outputs.
// - Ports differ in width except under ECC or FIFO.
// - Bits packed word by word from LSB upward.
// - Writes disabled makes the tile a ROM.
// - Address and data registered before the array.
// - Port reset clears its output, async or sync.
// - Global active-low reset clears both outputs.
// - Pipeline registers reset like the output latches.
package block_ram_pkg;
  localparam int ROWS   = 512;  // Physical rows of the array.
  localparam int ROW_W  = 36;   // Bits per row; every width divides it.
  localparam int ROW_AW = 9;    // Row index width.
  localparam int ADDR_W = 14;   // Port address width (16,384 x 1).
  localparam int BIT_AW = 15;   // Linear bit index width.
  localparam int LANE_W = 9;    // Byte plus parity.
  localparam int LANES  = 4;    // Lanes in a 36-bit row.
  localparam int ECC_DW = 32;   // Data bits under ECC.
  localparam int ECC_W  = 7;    // Six Hamming bits and one overall.
  localparam int CNT_W  = 10;   // FIFO occupancy counter width.
  localparam int IRQ_W  = 4;    // Interrupt sources.
  // Register offsets (byte addresses).
  localparam logic [7:0] OFF_CONFIG     = 8'h00;
  localparam logic [7:0] OFF_THRESH     = 8'h04;
  localparam logic [7:0] OFF_STATUS     = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h10;
  // Configuration field positions.
  localparam int CFG_MODE  = 0;   // Five bits, one-hot mode.
  localparam int CFG_AWID  = 8;   // Three bits, port A width code.
  localparam int CFG_BWID  = 12;  // Three bits, port B width code.
  localparam int CFG_ECC   = 16;  // Error correction enable.
  localparam int CFG_PAR   = 17;  // Parity generation enable.
  localparam int CFG_OREG  = 18;  // Output pipeline register enable.
  localparam int CFG_ASYNC = 19;  // Output resets act asynchronously.
  localparam logic [31:0] CONFIG_RESET = 32'h0000_5501;
  // Threshold fields and status positions.
  localparam int TH_AF = 0;       // Almost-full threshold, ten bits.
  localparam int TH_AE = 16;      // Almost-empty threshold, ten bits.
  localparam logic [31:0] THRESH_RESET = 32'h0004_01fc;
  localparam int ST_FLAGS = 16;   // Four flag bits above the count.
  // Interrupt bit positions.
  localparam int IRQ_SINGLE = 0;
  localparam int IRQ_DOUBLE = 1;
  localparam int IRQ_OVER   = 2;
  localparam int IRQ_UNDER  = 3;
  // Width codes.
  localparam logic [2:0] W1  = 3'h0;
  localparam logic [2:0] W2  = 3'h1;
  localparam logic [2:0] W4  = 3'h2;
  localparam logic [2:0] W9  = 3'h3;
  localparam logic [2:0] W18 = 3'h4;
  localparam logic [2:0] W36 = 3'h5;

  typedef enum logic [4:0] {
    MODE_SP   = 5'h01,
    MODE_TDP  = 5'h02,
    MODE_PDP  = 5'h04,
    MODE_ROM  = 5'h08,
    MODE_FIFO = 5'h10
  } mode_t;

  // One registered port request from the fabric.
  typedef struct packed {
    logic              en;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [ROW_W-1:0]  wdata;
    logic [LANES-1:0]  be;
  } port_req_t;

  typedef struct packed {
    logic full;
    logic almost_full;
    logic empty;
    logic almost_empty;
  } fifo_flags_t;
endpackage

//--- src/embedded_block_ram.sv
`timescale 1ns/1ps
`default_nettype none
module embedded_block_ram
  import block_ram_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire port_req_t   port_a_req,
  input  wire port_req_t   port_b_req,
  input  wire logic        port_a_output_reset,
  input  wire logic        port_b_output_reset,
  input  wire logic        global_reset_n,
  output logic [ROW_W-1:0] port_a_rdata,
  output logic [ROW_W-1:0] port_b_rdata,
  output logic             ecc_single_err,
  output logic             ecc_double_err,
  output fifo_flags_t      fifo_flags,
  output logic             irq
);

  // Number of bits in one word for a width code.
  function automatic logic [5:0] width_of(input logic [2:0] code);
    unique case (code)
      W1:      width_of = 6'h01;
      W2:      width_of = 6'h02;
      W4:      width_of = 6'h04;
      W9:      width_of = 6'h09;
      W18:     width_of = 6'h12;
      default: width_of = 6'h24;
    endcase
  endfunction

  // Row mask for one word, with lanes dropped by byte enables.
  function automatic logic [ROW_W-1:0] word_mask(input logic [2:0] code,
                                                 input logic [3:0] be);
    logic [ROW_W-1:0] m;
    m = '0;
    for (int i = 0; i < ROW_W; i++) begin
      m[i] = (i < int'(width_of(code)));
    end
    if (code == W18 || code == W36) begin
      for (int i = 0; i < ROW_W; i++) begin
        m[i] = m[i] & be[i / LANE_W];
      end
    end
    return m;
  endfunction

  // Word address to row and bit offset, packing LSB of word 0 first.
  function automatic logic [14:0] locate(input logic [ADDR_W-1:0] addr,
                                         input logic [2:0] code);
    logic [BIT_AW-1:0] base;
    // Widen both factors first so a deep word address cannot wrap.
    base = BIT_AW'(addr) * BIT_AW'(width_of(code));
    return {ROW_AW'(base / ROW_W), 6'(base % ROW_W)};
  endfunction

  // Fill the ninth bit of each lane with the parity of its byte.
  function automatic logic [ROW_W-1:0] add_parity(input logic [ROW_W-1:0] d);
    logic [ROW_W-1:0] r;
    r = d;
    for (int l = 0; l < LANES; l++) begin
      r[l*LANE_W+8] = ^d[l*LANE_W +: 8];
    end
    return r;
  endfunction

  // Hamming position of data bit i; powers of two hold check bits.
  function automatic int data_pos(input int i);
    int p;
    p = 3;
    for (int k = 0; k <= i; k++) begin
      if ((p & (p - 1)) == 0) p = p + 1;
      if (k < i) p = p + 1;
    end
    return p;
  endfunction

  // Check bits for a 32-bit word.
  function automatic logic [ECC_W-1:0] ecc_encode(input logic [31:0] d);
    logic [ECC_W-1:0] c;
    int p;
    c = '0;
    for (int i = 0; i < ECC_DW; i++) begin
      p = data_pos(i);
      for (int k = 0; k < ECC_W - 1; k++) begin
        if (p[k]) c[k] = c[k] ^ d[i];
      end
    end
    c[ECC_W-1] = ^{d, c[ECC_W-2:0]};
    return c;
  endfunction

  // Checked word: {single, double, corrected data}.
  function automatic logic [33:0] ecc_decode(input logic [31:0] d,
                                             input logic [ECC_W-1:0] c);
    logic [5:0]  syn;
    logic        odd;
    logic [31:0] fix;
    logic [ECC_W-1:0] enc;  // Check bits recomputed from the read data.
    enc = ecc_encode(d);
    syn = enc[5:0] ^ c[5:0];
    odd = ^{d, c};
    fix = d;
    for (int i = 0; i < ECC_DW; i++) begin
      if (odd && syn == 6'(data_pos(i))) fix[i] = ~d[i];
    end
    return {odd, ~odd & (syn != 6'h00), fix};
  endfunction

  // Software-visible state.
  logic [31:0]      cfg;          // Mode, widths and options.
  logic [31:0]      thresh;       // FIFO almost-full and almost-empty.
  logic [IRQ_W-1:0] irq_status;   // Sticky events, write one to clear.
  logic [IRQ_W-1:0] irq_mask;     // Enables for the interrupt output.
  mode_t            mode;
  logic             ecc_en;
  logic             oreg_en;
  logic             rst_async;

  assign mode      = mode_t'(cfg[CFG_MODE +: 5]);
  assign ecc_en    = cfg[CFG_ECC];
  assign oreg_en   = cfg[CFG_OREG];
  assign rst_async = cfg[CFG_ASYNC];

  // Storage: data rows and the check bits used only under ECC.
  logic [ROW_W-1:0] mem [ROWS];
  logic [ECC_W-1:0] chk [ROWS];

  // Registered port requests.
  port_req_t a_q;  // Port A after its input register.
  port_req_t b_q;  // Port B after its input register.

  // Fabric requests are captured before any array access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_q <= '0;
      b_q <= '0;
    end else begin
      a_q <= port_a_req;
      b_q <= port_b_req;
    end
  end

  // FIFO pointers and occupancy.
  logic [ROW_AW-1:0] wr_ptr;
  logic [ROW_AW-1:0] rd_ptr;
  logic [CNT_W-1:0]  count;
  logic [CNT_W-1:0]  next_count;

  // Per-mode decode of what each port may do this cycle.
  logic a_wr, a_rd, b_wr, b_rd, push, pop, over, under;
  logic [2:0] a_code, b_code;

  always_comb begin
    a_wr = 1'b0;
    a_rd = 1'b0;
    b_wr = 1'b0;
    b_rd = 1'b0;
    push = 1'b0;
    pop  = 1'b0;
    unique case (mode)
      MODE_SP: begin
        a_wr = a_q.en & a_q.we;
        a_rd = a_q.en & ~a_q.we;
      end
      MODE_TDP: begin
        a_wr = a_q.en & a_q.we;
        a_rd = a_q.en & ~a_q.we;
        b_wr = b_q.en & b_q.we;
        b_rd = b_q.en & ~b_q.we;
      end
      MODE_PDP: begin
        a_wr = a_q.en & a_q.we;
        b_rd = b_q.en & ~b_q.we;
      end
      MODE_ROM: begin
        // Write strobes are ignored so preloaded contents stay fixed.
        a_rd = a_q.en & ~a_q.we;
        b_rd = b_q.en & ~b_q.we;
      end
      MODE_FIFO: begin
        push = a_q.en & a_q.we & ~fifo_flags.full;
        pop  = b_q.en & ~b_q.we & ~fifo_flags.empty;
      end
      default: begin
        // An unknown mode code does nothing to the array.
      end
    endcase
    over  = (mode == MODE_FIFO) & a_q.en & a_q.we & fifo_flags.full;
    under = (mode == MODE_FIFO) & b_q.en & ~b_q.we & fifo_flags.empty;
    // ECC and FIFO run whole rows; without ECC, true dual port tops out at 18 bits.
    a_code = cfg[CFG_AWID +: 3];
    b_code = cfg[CFG_BWID +: 3];
    if (a_code > W36) a_code = W36;
    if (b_code > W36) b_code = W36;
    if (mode == MODE_TDP && a_code == W36) a_code = W18;
    if (mode == MODE_TDP && b_code == W36) b_code = W18;
    if (ecc_en || mode == MODE_FIFO) begin
      a_code = W36;
      b_code = W36;
    end
  end

  // Row, offset, mask and merged write row for each port.
  logic [14:0]       a_loc, b_loc;
  logic [ROW_AW-1:0] a_row, b_row;
  logic [5:0]        a_off, b_off;
  logic [ROW_W-1:0]  a_mask, b_mask, a_wd, b_wd, a_new, b_new;
  logic [ROW_W-1:0]  a_raw, b_raw;
  logic [33:0]       a_dec, b_dec;

  always_comb begin
    a_loc  = locate(a_q.addr, a_code);
    b_loc  = locate(b_q.addr, b_code);
    a_row  = (mode == MODE_FIFO) ? wr_ptr : a_loc[14:6];
    b_row  = (mode == MODE_FIFO) ? rd_ptr : b_loc[14:6];
    a_off  = (mode == MODE_FIFO) ? 6'h00 : a_loc[5:0];
    b_off  = (mode == MODE_FIFO) ? 6'h00 : b_loc[5:0];
    a_mask = word_mask(a_code, (ecc_en | mode == MODE_FIFO) ? 4'hf : a_q.be);
    b_mask = word_mask(b_code, b_q.be);
    a_wd   = cfg[CFG_PAR] ? add_parity(a_q.wdata) : a_q.wdata;
    b_wd   = cfg[CFG_PAR] ? add_parity(b_q.wdata) : b_q.wdata;
    // Under ECC only the low 32 bits of a port A write are stored.
    if (ecc_en) a_wd = {4'h0, a_q.wdata[ECC_DW-1:0]};
    a_new  = (mem[a_row] & ~(a_mask << a_off)) | ((a_wd & a_mask) << a_off);
    b_new  = (mem[b_row] & ~(b_mask << b_off)) | ((b_wd & b_mask) << b_off);
    a_raw  = (mem[a_row] >> a_off) & word_mask(a_code, 4'hf);
    b_raw  = (mem[b_row] >> b_off) & word_mask(b_code, 4'hf);
    a_dec  = ecc_decode(a_raw[ECC_DW-1:0], chk[a_row]);
    b_dec  = ecc_decode(b_raw[ECC_DW-1:0], chk[b_row]);
  end

  // Array writes. Port B lands last, so a same-row collision keeps B.
  always_ff @(posedge pclk) begin
    if (a_wr || push) begin
      mem[a_row] <= a_new;
      chk[a_row] <= ecc_encode(a_wd[ECC_DW-1:0]);
    end
    if (b_wr) begin
      mem[b_row] <= b_new;
    end
  end

  // FIFO pointers; full and empty already block the bad moves.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + ROW_AW'(1);
      if (pop)  rd_ptr <= rd_ptr + ROW_AW'(1);
      count <= next_count;
    end
  end

  assign next_count = count + CNT_W'(push) - CNT_W'(pop);

  // Flags follow the occupancy that the next cycle will hold.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_flags <= '{1'b0, 1'b0, 1'b1, 1'b1};
    end else begin
      fifo_flags.full         <= next_count == CNT_W'(ROWS);
      fifo_flags.empty        <= next_count == '0;
      fifo_flags.almost_full  <= next_count >= thresh[TH_AF +: CNT_W];
      fifo_flags.almost_empty <= next_count <= thresh[TH_AE +: CNT_W];
    end
  end

  // Read data entering each output latch.
  logic [ROW_W-1:0] next_a_lat, next_b_lat;
  logic             a_load, b_load;

  always_comb begin
    a_load     = a_rd;
    b_load     = b_rd | pop;
    next_a_lat = ecc_en ? {4'h0, a_dec[31:0]} : a_raw;
    next_b_lat = ecc_en ? {4'h0, b_dec[31:0]} : b_raw;
  end

  // Derived resets: the async form pulls the flop reset directly.
  logic a_arst_n, b_arst_n, a_sclr, b_sclr;
  assign a_arst_n = presetn &
    ~(rst_async & (port_a_output_reset | ~global_reset_n));
  assign b_arst_n = presetn &
    ~(rst_async & (port_b_output_reset | ~global_reset_n));
  assign a_sclr = ~rst_async & (port_a_output_reset | ~global_reset_n);
  assign b_sclr = ~rst_async & (port_b_output_reset | ~global_reset_n);

  logic [ROW_W-1:0] a_lat;  // Port A output latch.
  logic [ROW_W-1:0] b_lat;  // Port B output latch.

  // Port A latch and optional pipeline stage share one reset.
  always_ff @(posedge pclk or negedge a_arst_n) begin
    if (!a_arst_n) begin
      a_lat        <= '0;
      port_a_rdata <= '0;
    end else if (a_sclr) begin
      a_lat        <= '0;
      port_a_rdata <= '0;
    end else begin
      if (a_load) a_lat <= next_a_lat;
      // Without the pipeline the output tracks the latch itself.
      if (oreg_en) port_a_rdata <= a_lat;
      else if (a_load) port_a_rdata <= next_a_lat;
    end
  end

  // Port B latch and optional pipeline stage share one reset.
  always_ff @(posedge pclk or negedge b_arst_n) begin
    if (!b_arst_n) begin
      b_lat        <= '0;
      port_b_rdata <= '0;
    end else if (b_sclr) begin
      b_lat        <= '0;
      port_b_rdata <= '0;
    end else begin
      if (b_load) b_lat <= next_b_lat;
      if (oreg_en) port_b_rdata <= b_lat;
      else if (b_load) port_b_rdata <= next_b_lat;
    end
  end

  // Error flags are one-cycle pulses, aligned with the latch load.
  logic sbe, dbe;
  assign sbe = ecc_en & ((a_load & a_dec[33]) | (b_load & b_dec[33]));
  assign dbe = ecc_en & ((a_load & a_dec[32]) | (b_load & b_dec[32]));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecc_single_err <= 1'b0;
      ecc_double_err <= 1'b0;
    end else begin
      ecc_single_err <= sbe;
      ecc_double_err <= dbe;
    end
  end

  // APB decode: pready rises for the access phase, so no wait states.
  logic apb_wr;
  logic [IRQ_W-1:0] events;
  assign apb_wr = psel & penable & pready & pwrite & ~pslverr;
  assign events = {under, over, dbe, sbe};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > OFF_IRQ_MASK | paddr[1:0] != 2'h0);
      unique case (paddr)
        OFF_CONFIG:     prdata <= cfg;
        OFF_THRESH:     prdata <= thresh;
        OFF_STATUS:     prdata <= {12'h000, fifo_flags, 6'h00, count};
        OFF_IRQ_STATUS: prdata <= {28'h0, irq_status};
        OFF_IRQ_MASK:   prdata <= {28'h0, irq_mask};
        default:        prdata <= '0;
      endcase
    end
  end

  // Configuration registers take effect at the access edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg      <= CONFIG_RESET;
      thresh   <= THRESH_RESET;
      irq_mask <= '0;
    end else if (apb_wr) begin
      if (paddr == OFF_CONFIG)   cfg      <= pwdata;
      if (paddr == OFF_THRESH)   thresh   <= pwdata;
      if (paddr == OFF_IRQ_MASK) irq_mask <= pwdata[IRQ_W-1:0];
    end
  end

  // Sticky status: an event in the clearing cycle survives the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
      irq        <= 1'b0;
    end else begin
      irq_status <= (irq_status &
        ~((apb_wr && paddr == OFF_IRQ_STATUS) ? pwdata[IRQ_W-1:0] : '0))
        | events;
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule
`default_nettype wire

//--- test/block_ram_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the register bus, the FIFO flags, the port A output reset and the global reset.
module block_ram_checker
  import block_ram_pkg::*;
(
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic [7:0]       paddr,
  input wire logic             pwrite,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic             port_a_output_reset,
  input wire logic             global_reset_n,
  input wire logic [ROW_W-1:0] port_a_rdata,
  input wire logic [ROW_W-1:0] port_b_rdata,
  input wire fifo_flags_t      fifo_flags
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic bad_addr;  // Address outside the five registers or not aligned.
  assign bad_addr = (paddr > 8'h10) || (paddr[1:0] != 2'h0);
  // A setup cycle, and the access cycle that ends it.
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_done;
    psel && penable && pready;
  endsequence
  chk_ready_after_setup: assert property (apb_setup |=> apb_done)
    else $error("no answer in first access cycle");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_err_bad_addr: assert property (apb_setup ##0 bad_addr |=> pslverr)
    else $error("unmapped address not refused");
  chk_err_good_addr: assert property (apb_setup ##0 !bad_addr |=> !pslverr)
    else $error("mapped address refused");
  chk_err_read_zero: assert property (apb_done ##0 pslverr && !pwrite
    |-> prdata == 32'h0) else $error("refused read returned data");
  chk_flags_exclusive: assert property (
    !(fifo_flags.full && fifo_flags.empty))
    else $error("fifo full and empty together");
  chk_empty_almost: assert property (
    fifo_flags.empty |-> fifo_flags.almost_empty)
    else $error("empty without almost empty");
  chk_port_reset: assert property (
    port_a_output_reset |=> port_a_rdata == '0)
    else $error("port reset left data");
  chk_global_reset: assert property (
    !global_reset_n |=> port_a_rdata == '0 && port_b_rdata == '0)
    else $error("global reset left data");
endmodule
`default_nettype wire

//--- test/fabric_model.sv
`timescale 1ns/1ps
`default_nettype none
// Fabric logic driving both ports; it tracks when read data is due.
module fabric_model
  import block_ram_pkg::*;
(
  input  wire logic      pclk,
  output var port_req_t  port_a_req,
  output var port_req_t  port_b_req,
  output var logic [1:0] a_due,
  output var logic [1:0] b_due
);
  initial begin
    port_a_req = '0;
    port_b_req = '0;
  end
  // A read sampled at one edge has its data in the latch after the next.
  always @(posedge pclk) begin
    a_due <= {a_due[0], port_a_req.en & ~port_a_req.we};
    b_due <= {b_due[0], port_b_req.en & ~port_b_req.we};
  end
  // Puts one request on a port and holds it until the edge takes it.
  task automatic drive(input logic b, input logic w,
                       input logic [ADDR_W-1:0] a,
                       input logic [ROW_W-1:0] d, input logic [LANES-1:0] e);
    port_req_t r;
    r = '{en: 1'b1, we: w, addr: a, wdata: d, be: e};
    if (b) port_b_req <= r;
    else port_a_req <= r;
    @(posedge pclk);
  endtask
  // Idle lines flip, so stale values are never mistaken for held ones.
  task automatic rest();
    port_a_req <= '{1'b0, 1'b0, ~port_a_req.addr, ~port_a_req.wdata, 4'h0};
    port_b_req <= '{1'b0, 1'b0, ~port_b_req.addr, ~port_b_req.wdata, 4'h0};
  endtask
endmodule
`default_nettype wire

//--- test/embedded_block_ram_test.sv
`timescale 1ns/1ps
`default_nettype none
module embedded_block_ram_test;
  import block_ram_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h0;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  port_req_t         port_a_req;
  port_req_t         port_b_req;
  logic              port_a_output_reset = 1'b0;
  logic              port_b_output_reset = 1'b0;
  logic              global_reset_n = 1'b1;
  logic [ROW_W-1:0]  port_a_rdata;
  logic [ROW_W-1:0]  port_b_rdata;
  logic              ecc_single_err;
  logic              ecc_double_err;
  fifo_flags_t       fifo_flags;
  logic              irq;
  logic [1:0]        a_due;
  logic [1:0]        b_due;
  logic [31:0]       q_reg[$];   // Expected register reads.
  logic [71:0]       q_a[$];     // Mask and value expected on port A.
  logic [71:0]       q_b[$];     // Mask and value expected on port B.
  logic [71:0]       ma;
  logic [71:0]       mb;
  logic [35:0]       d[8];
  logic [35:0]       x;
  int                n_errors = 0;
  int                n_checks = 0;
  int                seed = 96;
  embedded_block_ram embedded_block_ram_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_a_req(port_a_req), .port_b_req(port_b_req),
    .port_a_output_reset(port_a_output_reset),
    .port_b_output_reset(port_b_output_reset),
    .global_reset_n(global_reset_n), .port_a_rdata(port_a_rdata),
    .port_b_rdata(port_b_rdata), .ecc_single_err(ecc_single_err),
    .ecc_double_err(ecc_double_err), .fifo_flags(fifo_flags), .irq(irq));
  fabric_model fabric_model_i (.pclk(pclk), .port_a_req(port_a_req),
    .port_b_req(port_b_req), .a_due(a_due), .b_due(b_due));
  always #5 pclk = ~pclk;
  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One bus transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      give_verdict();
    end
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q_reg.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // A port request; reads note the expected data before they go out.
  task automatic port_op(input logic b, input logic w,
                         input logic [ADDR_W-1:0] a, input logic [35:0] v,
                         input logic [3:0] e, input logic [35:0] ex,
                         input logic [35:0] mk);
    if (!w && b) q_b.push_back({mk, ex});
    else if (!w) q_a.push_back({mk, ex});
    fabric_model_i.drive(b, w, a, v, e);
    fabric_model_i.rest();
    repeat (2) @(posedge pclk);
  endtask
  // Result watchers: each result that appears takes the oldest note.
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && q_reg.size() > 0)
      cmp({4'h0, prdata}, {4'h0, q_reg.pop_front()});
  always @(negedge pclk) begin
    if (a_due[1] && q_a.size() > 0) begin
      ma = q_a.pop_front();
      cmp(port_a_rdata & ma[71:36], ma[35:0]);
      cmp({34'h0, ecc_double_err, ecc_single_err}, 36'h0);
    end
    if (b_due[1] && q_b.size() > 0) begin
      mb = q_b.pop_front();
      cmp(port_b_rdata & mb[71:36], mb[35:0]);
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_CONFIG, CONFIG_RESET);
    rd(OFF_THRESH, THRESH_RESET);
    rd(8'h14, 32'h0);
    apb(1'b1, OFF_IRQ_MASK, 32'hf);
    rd(OFF_IRQ_MASK, 32'hf);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      d[i] = {4'($random(seed)), 32'($random(seed))};
      port_op(1'b0, 1'b1, 14'(i * 37), d[i], 4'hf, 36'h0, 36'h0);
    end
    for (int i = 0; i < 8; i++)
      port_op(1'b0, 1'b0, 14'(i * 37), 36'h0, 4'h0, d[i], '1);
    x = {4'($random(seed)), 32'($random(seed))};
    port_op(1'b0, 1'b1, 14'h0, x, 4'h2, 36'h0, 36'h0);
    x = {d[0][35:18], x[17:9], d[0][8:0]};
    port_op(1'b0, 1'b0, 14'h0, 36'h0, 4'h0, x, '1);
    $display("test single port done");
    apb(1'b1, OFF_CONFIG, 32'h0000_3504);
    for (int n = 0; n < 4; n++)
      port_op(1'b1, 1'b0, 14'(n), 36'h0, 4'h0, {27'h0, x[9*n +: 9]},
              36'h1ff);
    apb(1'b1, OFF_CONFIG, 32'h0000_5502);
    port_op(1'b1, 1'b0, 14'h1, 0, 0, {18'h0, x[35:18]}, '1);
    apb(1'b1, OFF_CONFIG, 32'h0002_5501);
    port_op(1'b0, 1'b1, 14'h9, 36'h1, 4'hf, 0, 0);
    port_op(1'b0, 1'b0, 14'h9, 0, 0, 36'h101, '1);
    apb(1'b1, OFF_CONFIG, 32'h0001_5501);
    port_op(1'b0, 1'b1, 14'h5, {4'h0, d[1][31:0]}, 4'hf, 0, 0);
    port_op(1'b0, 1'b0, 14'h5, 0, 0, {4'h0, d[1][31:0]}, '1);
    apb(1'b1, OFF_CONFIG, 32'h0000_5501);
    port_op(1'b0, 1'b1, 14'h7, x, 4'hf, 0, 0);
    apb(1'b1, OFF_CONFIG, 32'h0000_5508);
    port_op(1'b0, 1'b1, 14'h7, ~x, 4'hf, 0, 0);
    port_op(1'b0, 1'b0, 14'h7, 0, 0, x, '1);
    $display("test ecc and rom done");
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, OFF_CONFIG, 32'h0000_5501 | (32'(k % 2) << 19));
      port_op(1'b0, 1'b0, 14'h7, 0, 0, x, '1);
      port_a_output_reset <= (k < 2);
      port_b_output_reset <= (k < 2);
      global_reset_n <= (k < 2);
      if (k % 2 == 0) @(posedge pclk);
      #1;
      cmp(port_a_rdata, 36'h0);
      @(posedge pclk);
      port_a_output_reset <= 1'b0;
      port_b_output_reset <= 1'b0;
      global_reset_n <= 1'b1;
    end
    $display("test output resets done");
    apb(1'b1, OFF_CONFIG, 32'h0000_5510);
    apb(1'b1, OFF_THRESH, 32'h0004_0005);
    rd(OFF_STATUS, 32'h0003_0000);
    port_op(1'b1, 1'b0, 14'h0, 0, 0, 0, '1);
    @(negedge pclk);
    cmp({35'h0, irq}, 36'h1);
    @(posedge pclk);
    rd(OFF_IRQ_STATUS, 32'h8);
    apb(1'b1, OFF_IRQ_MASK, 32'h0);
    @(negedge pclk);
    cmp({35'h0, irq}, 36'h0);
    @(posedge pclk);
    apb(1'b1, OFF_IRQ_STATUS, 32'h8);
    rd(OFF_IRQ_STATUS, 32'h0);
    for (int i = 0; i < 5; i++) begin
      port_op(1'b0, 1'b1, 14'h0, d[i], 4'hf, 0, 0);
      if (i == 3) rd(OFF_STATUS, 32'h0001_0004);
    end
    rd(OFF_STATUS, 32'h0004_0005);
    for (int i = 0; i < 5; i++)
      port_op(1'b1, 1'b0, 14'h0, 0, 0, d[i], '1);
    rd(OFF_STATUS, 32'h0003_0000);
    $display("test fifo and interrupt done");
    give_verdict();
  end
endmodule
bind embedded_block_ram block_ram_checker block_ram_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .port_a_output_reset(port_a_output_reset),
  .global_reset_n(global_reset_n), .port_a_rdata(port_a_rdata),
  .port_b_rdata(port_b_rdata), .fifo_flags(fifo_flags));
`default_nettype wire
